// >>> rtl/dtmp_regs.vh
// Constants for the DMA transfer mode and priority arbiter block.
`ifndef DTMP_REGS_VH
`define DTMP_REGS_VH

// Controller states, one bus state per clock.
`define DTMP_ST_IDLE 4'h0
`define DTMP_ST_HOLD 4'h1
`define DTMP_ST_ARB 4'h2
`define DTMP_ST_REQA 4'h3
`define DTMP_ST_TGTA 4'h4
`define DTMP_ST_RFSH 4'h5
`define DTMP_ST_RELD 4'h6
`define DTMP_ST_TAIL 4'h7
`define DTMP_ST_REL 4'h8

// Bus-state counts.
`define DTMP_RELOAD_STATES 3'h7
`define DTMP_TAIL_STATES 3'h2

// Priority group select and slot codes.
`define DTMP_GROUP_LOWER 1'b0
`define DTMP_GROUP_UPPER 1'b1
`define DTMP_LOWER_SLOT 3'h4
`define DTMP_UPPER_SLOTS 3'h5

// Reset values of the programmed and current lowest-priority positions.
`define DTMP_LOWER_LOW_RESET 2'h3
`define DTMP_UPPER_LOW_RESET 3'h3
`define DTMP_UPPER_PROG_RESET 2'h3

`endif

// >>> rtl/dtmp_core.v
// DMA transfer-mode sequencer (Block and Demand) with cascaded eight-channel priority arbiter.
`timescale 1ns/10ps
// How it works
// - Block mode keeps transferring until byte count expires or end-of-process input.
// - A running Block transfer yields only to a memory refresh cycle.
// - Demand mode runs to count or end-of-process; dropping the request pauses it.
// - Demand request is sampled only in requester accesses; inactive means last access.
// - On pause finish the target access, release bus, keep count and state.
// - A paused Demand channel re-arbitrates and resumes from its saved count.
// - First bus access starts two bus states after hold acknowledge goes active.
// - Bus returns to the host one bus state after the request goes inactive.
// - Auto-initialize end spends seven held bus states reloading current from base.
// - Requester-source two-cycle transfers add two idle states before dropping hold.
// - Channels 0-3 and 4-7 are cascaded groups; lower group sits between 7 and 4.
// - After reset priority is fixed, channel 0 highest down to channel 7 lowest.
// - Each arbitration services the requesting channel with the highest priority.
// - Software sets each group's lowest channel; the next one cyclically is highest.
// - A programmable-priority command is ignored unless its group is in fixed mode.
// - Fixed to rotating keeps order; rotating to fixed restores the programmed order.
// - In rotating mode the serviced channel drops to lowest within its group.
// - Lower-group service with rotating upper group also drops the lower slot.
// - Hold request is asserted one bus state after a service request appears.
// - Priority is resolved in the first state after acknowledge; transfer starts next.
`include "dtmp_regs.vh"

module dtmp_core #(
    parameter CW = 16
) (
    input wire CLOCK,
    input wire RESET,
    input wire [7:0] CHANNEL_SERVICE_REQUEST,
    input wire END_OF_PROCESS_INPUT,
    input wire BUS_HOLD_ACK,
    input wire REFRESH_REQUEST,
    input wire [7:0] CHANNEL_DEMAND_MODE,
    input wire [7:0] CHANNEL_AUTO_INIT,
    input wire [7:0] CHANNEL_REQUESTER_SOURCE,
    input wire [7:0] CHANNEL_TWO_CYCLE,
    input wire COUNT_WRITE,
    input wire [2:0] COUNT_CHANNEL,
    input wire [CW-1:0] COUNT_VALUE,
    input wire PRIORITY_MODE_WRITE,
    input wire PRIORITY_GROUP,
    input wire PRIORITY_ROTATE,
    input wire PROGRAM_PRIORITY_WRITE,
    input wire [1:0] PROGRAM_LOWEST,
    output reg BUS_HOLD_REQUEST,
    output wire REQUESTER_ACCESS,
    output wire TARGET_ACCESS,
    output wire REFRESH_ACCESS,
    output wire RELOAD_BUSY,
    output reg [2:0] ACTIVE_CHANNEL,
    output reg [7:0] CHANNEL_DONE,
    output reg LOWER_ROTATING,
    output reg UPPER_ROTATING,
    output reg [1:0] LOWER_LOWEST,
    output reg [2:0] UPPER_LOWEST
);

    // Sequencer state and the counter for the reload and tail spans.
    reg [3:0] state;
    reg [2:0] wait_count;

    // Programmed lowest positions, restored when a group returns to fixed mode.
    reg [1:0] lower_prog;
    reg [1:0] upper_prog;

    // Demand pause and end-of-process, both taken in the requester access.
    reg last_request;
    reg eop_seen;

    // Per-channel counts; the base copy feeds the auto-initialize reload.
    reg [CW-1:0] current_count [0:7];
    reg [CW-1:0] base_count [0:7];
    wire [7:0] eligible;
    wire [CW-1:0] active_count;
    wire terminal;
    wire tail_needed;

    // Arbiter results: the top bit flags a hit, the low bits name a channel or slot.
    reg [2:0] lower_pick;
    reg [3:0] upper_pick;
    reg [3:0] winner;

    // Scratch for the two cyclic searches, each with its own loop index.
    reg [31:0] lower_index;
    reg [31:0] upper_index;
    reg upper_hit;
    integer i;
    integer j;

    // A channel whose single-buffer process ended waits for a new count.
    assign eligible = CHANNEL_SERVICE_REQUEST & ~CHANNEL_DONE;
    assign active_count = current_count[ACTIVE_CHANNEL];
    // Count expired (reads zero in the target access, which is then the last) or end-of-process sampled in the access.
    assign terminal = (active_count == {CW{1'b0}}) | eop_seen;
    assign tail_needed = CHANNEL_REQUESTER_SOURCE[ACTIVE_CHANNEL]
        & CHANNEL_TWO_CYCLE[ACTIVE_CHANNEL];

    // Bus strobes decode straight from the state register.
    assign REQUESTER_ACCESS = (state == `DTMP_ST_REQA);
    assign TARGET_ACCESS = (state == `DTMP_ST_TGTA);
    assign REFRESH_ACCESS = (state == `DTMP_ST_RFSH);
    assign RELOAD_BUSY = (state == `DTMP_ST_RELD);

    // Cyclic search inside the lower group starting just after its lowest channel.
    // The search runs from the far end, so the nearest requester, which holds the
    // highest priority, is the last one to write the result.
    always @* begin
        lower_pick = 3'h0;
        lower_index = 32'h0;
        for (i = 4; i >= 1; i = i - 1) begin
            lower_index = (LOWER_LOWEST + i) % 4;
            if (eligible[lower_index[1:0]]) begin
                lower_pick = {1'b1, lower_index[1:0]};
            end
        end
    end

    // Upper group has five slots in the cyclic order 4,5,6,7,lower-group.
    // Slot 4 hits when the lower group has a winner of its own, which is what
    // makes the lower group behave as one channel of the upper group.
    always @* begin
        upper_pick = 4'h0;
        upper_index = 32'h0;
        upper_hit = 1'b0;
        for (j = 5; j >= 1; j = j - 1) begin
            upper_index = (UPPER_LOWEST + j) % `DTMP_UPPER_SLOTS;
            if (upper_index[2:0] == `DTMP_LOWER_SLOT) begin
                upper_hit = lower_pick[2];
            end else begin
                upper_hit = eligible[{1'b1, upper_index[1:0]}];
            end
            if (upper_hit) begin
                upper_pick = {1'b1, upper_index[2:0]};
            end
        end
    end

    // Resolve the winning channel number; the lower slot defers to its own group.
    // Bit 3 flags that some channel won; without it the sequencer gives the bus back.
    always @* begin
        winner = 4'h0;
        if (upper_pick[3]) begin
            if (upper_pick[2:0] == `DTMP_LOWER_SLOT) begin
                winner = {2'b10, lower_pick[1:0]};
            end else begin
                winner = {1'b1, upper_pick[2:0] + 3'h4};
            end
        end
    end

    // Priority mode and programmable priority, shared by commands and rotation.
    always @(posedge CLOCK) begin
        if (RESET) begin
            LOWER_ROTATING <= 1'b0;
            UPPER_ROTATING <= 1'b0;
            lower_prog <= `DTMP_LOWER_LOW_RESET;
            upper_prog <= `DTMP_UPPER_PROG_RESET;
            LOWER_LOWEST <= `DTMP_LOWER_LOW_RESET;
            UPPER_LOWEST <= `DTMP_UPPER_LOW_RESET;
        end else begin
            // Rotation happens at the moment a channel wins service.
            if (state == `DTMP_ST_ARB && winner[3]) begin
                if (winner[2] == 1'b0) begin
                    if (LOWER_ROTATING) begin
                        LOWER_LOWEST <= winner[1:0];
                    end
                    if (UPPER_ROTATING) begin
                        UPPER_LOWEST <= `DTMP_LOWER_SLOT;
                    end
                end else if (UPPER_ROTATING) begin
                    UPPER_LOWEST <= {1'b0, winner[1:0]};
                end
            end
            // Mode change: entering rotating keeps the order, leaving restores it.
            // A mode write shadows a program write in the same state; the program is lost.
            if (PRIORITY_MODE_WRITE) begin
                if (PRIORITY_GROUP == `DTMP_GROUP_LOWER) begin
                    LOWER_ROTATING <= PRIORITY_ROTATE;
                    if (!PRIORITY_ROTATE) begin
                        LOWER_LOWEST <= lower_prog;
                    end
                end else begin
                    UPPER_ROTATING <= PRIORITY_ROTATE;
                    if (!PRIORITY_ROTATE) begin
                        UPPER_LOWEST <= {1'b0, upper_prog};
                    end
                end
            end else if (PROGRAM_PRIORITY_WRITE) begin
                // Only a group in fixed mode takes the command.
                if (PRIORITY_GROUP == `DTMP_GROUP_LOWER && !LOWER_ROTATING) begin
                    lower_prog <= PROGRAM_LOWEST;
                    LOWER_LOWEST <= PROGRAM_LOWEST;
                end
                if (PRIORITY_GROUP == `DTMP_GROUP_UPPER && !UPPER_ROTATING) begin
                    upper_prog <= PROGRAM_LOWEST;
                    UPPER_LOWEST <= {1'b0, PROGRAM_LOWEST};
                end
            end
        end
    end

    // Byte counts live per channel, so a paused Demand channel resumes where it stopped.
    // Counts have no reset: they mean nothing until software writes them.
    // A count write takes priority over the running decrement.
    always @(posedge CLOCK) begin
        if (COUNT_WRITE) begin
            current_count[COUNT_CHANNEL] <= COUNT_VALUE;
            base_count[COUNT_CHANNEL] <= COUNT_VALUE;
        end else if (state == `DTMP_ST_TGTA && !terminal) begin
            current_count[ACTIVE_CHANNEL] <= active_count - {{(CW-1){1'b0}}, 1'b1};
        end else if (state == `DTMP_ST_RELD && wait_count == 3'h1) begin
            current_count[ACTIVE_CHANNEL] <= base_count[ACTIVE_CHANNEL];
        end
    end

    // Transfer sequencer; each clock is one bus state.
    // A transfer walks IDLE, HOLD and ARB, then pairs of requester and target accesses.
    // The end of a process may add seven reload states or two tail states.
    // REL waits for the acknowledge to fall, so a new hold request never meets
    // a host that still believes it has granted the bus.
    always @(posedge CLOCK) begin
        if (RESET) begin
            state <= `DTMP_ST_IDLE;
            BUS_HOLD_REQUEST <= 1'b0;
            ACTIVE_CHANNEL <= 3'h0;
            CHANNEL_DONE <= 8'h00;
            wait_count <= 3'h0;
            last_request <= 1'b0;
            eop_seen <= 1'b0;
        end else begin
            // A new count rearms a finished channel; a finish in the same cycle wins.
            if (COUNT_WRITE) begin
                CHANNEL_DONE[COUNT_CHANNEL] <= 1'b0;
            end
            case (state)
                `DTMP_ST_IDLE: begin
                    // A done channel is masked, so a stale request cannot raise hold.
                    if (|eligible) begin
                        BUS_HOLD_REQUEST <= 1'b1;
                        state <= `DTMP_ST_HOLD;
                    end
                end
                `DTMP_ST_HOLD: begin
                    // The host may take any number of states to grant the bus.
                    if (BUS_HOLD_ACK) begin
                        state <= `DTMP_ST_ARB;
                    end
                end
                `DTMP_ST_ARB: begin
                    // Arbitration state; the access follows in the next state.
                    if (winner[3]) begin
                        ACTIVE_CHANNEL <= winner[2:0];
                        state <= `DTMP_ST_REQA;
                    end else begin
                        BUS_HOLD_REQUEST <= 1'b0;
                        state <= `DTMP_ST_REL;
                    end
                end
                `DTMP_ST_REQA: begin
                    // The request only matters here, and only in Demand mode.
                    last_request <= CHANNEL_DEMAND_MODE[ACTIVE_CHANNEL]
                        & ~CHANNEL_SERVICE_REQUEST[ACTIVE_CHANNEL];
                    eop_seen <= END_OF_PROCESS_INPUT;
                    state <= `DTMP_ST_TGTA;
                end
                `DTMP_ST_TGTA: begin
                    // Termination goes before the pause, so a last transfer is marked done.
                    eop_seen <= 1'b0;
                    if (terminal) begin
                        if (CHANNEL_AUTO_INIT[ACTIVE_CHANNEL]) begin
                            wait_count <= `DTMP_RELOAD_STATES;
                            state <= `DTMP_ST_RELD;
                        end else begin
                            CHANNEL_DONE[ACTIVE_CHANNEL] <= 1'b1;
                            if (tail_needed) begin
                                wait_count <= `DTMP_TAIL_STATES;
                                state <= `DTMP_ST_TAIL;
                            end else begin
                                BUS_HOLD_REQUEST <= 1'b0;
                                state <= `DTMP_ST_REL;
                            end
                        end
                    end else if (last_request) begin
                        // Pause after finishing the target access.
                        if (tail_needed) begin
                            wait_count <= `DTMP_TAIL_STATES;
                            state <= `DTMP_ST_TAIL;
                        end else begin
                            BUS_HOLD_REQUEST <= 1'b0;
                            state <= `DTMP_ST_REL;
                        end
                    end else if (REFRESH_REQUEST) begin
                        // Refresh slips in only between transfers, never inside one.
                        state <= `DTMP_ST_RFSH;
                    end else begin
                        state <= `DTMP_ST_REQA;
                    end
                end
                `DTMP_ST_RFSH: begin
                    // One refresh cycle, then the same channel carries on.
                    state <= `DTMP_ST_REQA;
                end
                `DTMP_ST_RELD: begin
                    // Reload happens with the bus still held.
                    wait_count <= wait_count - 3'h1;
                    if (wait_count == 3'h1) begin
                        if (tail_needed) begin
                            wait_count <= `DTMP_TAIL_STATES;
                            state <= `DTMP_ST_TAIL;
                        end else begin
                            BUS_HOLD_REQUEST <= 1'b0;
                            state <= `DTMP_ST_REL;
                        end
                    end
                end
                `DTMP_ST_TAIL: begin
                    // Idle states that let the internal pipeline drain.
                    wait_count <= wait_count - 3'h1;
                    if (wait_count == 3'h1) begin
                        BUS_HOLD_REQUEST <= 1'b0;
                        state <= `DTMP_ST_REL;
                    end
                end
                `DTMP_ST_REL: begin
                    // Wait for the host to take the bus back before a new request.
                    if (!BUS_HOLD_ACK) begin
                        state <= `DTMP_ST_IDLE;
                    end
                end
                default: begin
                    // An unused code drops the bus rather than hang with it held.
                    BUS_HOLD_REQUEST <= 1'b0;
                    state <= `DTMP_ST_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> test/dtmp_checker.sv
// Port-level checks for the DMA transfer-mode and priority core.
`timescale 1ns/10ps
module dtmp_checker (
    input wire CLOCK,
    input wire RESET,
    input wire [7:0] CHANNEL_SERVICE_REQUEST,
    input wire BUS_HOLD_ACK,
    input wire REFRESH_REQUEST,
    input wire [7:0] CHANNEL_DEMAND_MODE,
    input wire [7:0] CHANNEL_AUTO_INIT,
    input wire [7:0] CHANNEL_REQUESTER_SOURCE,
    input wire [7:0] CHANNEL_TWO_CYCLE,
    input wire PRIORITY_MODE_WRITE,
    input wire PRIORITY_GROUP,
    input wire PROGRAM_PRIORITY_WRITE,
    input wire [1:0] PROGRAM_LOWEST,
    input wire BUS_HOLD_REQUEST,
    input wire REQUESTER_ACCESS,
    input wire TARGET_ACCESS,
    input wire RELOAD_BUSY,
    input wire [2:0] ACTIVE_CHANNEL,
    input wire LOWER_ROTATING,
    input wire UPPER_ROTATING,
    input wire [1:0] LOWER_LOWEST,
    input wire [2:0] UPPER_LOWEST
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // A plain Demand pause; reload and tail would lengthen the release, refresh would not.
    wire plain = ~CHANNEL_AUTO_INIT[ACTIVE_CHANNEL] & ~REFRESH_REQUEST;
    wire tail = CHANNEL_REQUESTER_SOURCE[ACTIVE_CHANNEL] & CHANNEL_TWO_CYCLE[ACTIVE_CHANNEL];
    wire pause = CHANNEL_DEMAND_MODE[ACTIVE_CHANNEL] & ~CHANNEL_SERVICE_REQUEST[ACTIVE_CHANNEL];
    wire prog = PROGRAM_PRIORITY_WRITE & ~PRIORITY_MODE_WRITE & ~PRIORITY_GROUP;

    a_hold_follows_req: assert property ($rose(BUS_HOLD_REQUEST) |->
        $past(CHANNEL_SERVICE_REQUEST) != 8'h00)
        else $error("hold request rose without a service request");
    a_first_access: assert property ($rose(BUS_HOLD_ACK) && BUS_HOLD_REQUEST
        |=> !REQUESTER_ACCESS ##1 (REQUESTER_ACCESS || !BUS_HOLD_REQUEST))
        else $error("first access not two states after acknowledge");
    a_access_pair: assert property (REQUESTER_ACCESS |=> TARGET_ACCESS)
        else $error("requester access not followed by target access");
    a_demand_release: assert property (REQUESTER_ACCESS && pause && plain
        && !tail |=> TARGET_ACCESS ##1 !BUS_HOLD_REQUEST)
        else $error("paused demand transfer did not release the bus");
    a_reload_span: assert property ($rose(RELOAD_BUSY) |->
        (RELOAD_BUSY && BUS_HOLD_REQUEST) [*7] ##1 !RELOAD_BUSY)
        else $error("reload did not last seven held states");
    a_program_taken: assert property (prog && !LOWER_ROTATING |=>
        LOWER_LOWEST == $past(PROGRAM_LOWEST))
        else $error("programmed lowest channel not taken");
    a_program_refused: assert property (prog && LOWER_ROTATING && !BUS_HOLD_ACK |=>
        $stable(LOWER_LOWEST))
        else $error("programmed priority taken while rotating");
    a_lower_rotate: assert property (REQUESTER_ACCESS && LOWER_ROTATING
        && !ACTIVE_CHANNEL[2] |-> LOWER_LOWEST == ACTIVE_CHANNEL[1:0])
        else $error("serviced lower channel not moved to lowest");
    a_upper_rotate: assert property (REQUESTER_ACCESS && UPPER_ROTATING |->
        UPPER_LOWEST == (ACTIVE_CHANNEL[2] ? {1'b0, ACTIVE_CHANNEL[1:0]} : 3'h4))
        else $error("upper group slot not moved to lowest");
endmodule

// >>> test/dtmp_host_model.sv
// Host processor model that grants the bus after a chosen delay.
`timescale 1ns/10ps
module dtmp_host_model (
    input wire clock,
    input wire reset,
    input wire hold_request,
    input wire [1:0] ack_delay,
    output reg hold_ack
);
    reg [2:0] wait_count;
    // The grant is withdrawn at once when hold falls, so a slow host never overlaps.
    always @(posedge clock) begin
        if (reset || !hold_request) begin
            hold_ack <= 1'b0;
            wait_count <= 3'h0;
        end else if (wait_count >= {1'b0, ack_delay}) begin
            hold_ack <= 1'b1;
        end else begin
            wait_count <= wait_count + 3'h1;
        end
    end
endmodule

// >>> test/test_dma_transfer_mode_priority.sv
// Self-checking bench for the DMA transfer-mode and priority core.
`timescale 1ns/10ps
module test_dma_transfer_mode_priority;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] req = 8'h00, dem = 8'h00, ai = 8'h00, src = 8'h00, tc = 8'h00, m;
    reg eop = 1'b0, rfsh = 1'b0, cw = 1'b0, pmw = 1'b0, pg = 1'b0, pr = 1'b0, ppw = 1'b0;
    reg [2:0] cch = 3'h0, mul = 3'h3, w;
    reg [15:0] cval = 16'h0000;
    reg [1:0] pl = 2'h0, dly = 2'h0, mll = 2'h3;
    reg [31:0] seed = 32'h1d;
    reg [39:0] tbl = 40'h44c0810302;
    reg mlr = 1'b0, mur = 1'b0;
    integer bad_count = 0, cmp_count = 0, n, g, f, k, r;
    wire ack, hold, ra, ta, fa, rb, lr, ur;
    wire [2:0] ach, ul;
    wire [7:0] done;
    wire [1:0] ll;
    always #25 clk = ~clk;
    dtmp_core DUT (.CLOCK(clk), .RESET(rst), .CHANNEL_SERVICE_REQUEST(req),
        .END_OF_PROCESS_INPUT(eop), .BUS_HOLD_ACK(ack), .REFRESH_REQUEST(rfsh),
        .CHANNEL_DEMAND_MODE(dem), .CHANNEL_AUTO_INIT(ai), .CHANNEL_REQUESTER_SOURCE(src),
        .CHANNEL_TWO_CYCLE(tc), .COUNT_WRITE(cw), .COUNT_CHANNEL(cch), .COUNT_VALUE(cval),
        .PRIORITY_MODE_WRITE(pmw), .PRIORITY_GROUP(pg), .PRIORITY_ROTATE(pr),
        .PROGRAM_PRIORITY_WRITE(ppw), .PROGRAM_LOWEST(pl), .BUS_HOLD_REQUEST(hold),
        .REQUESTER_ACCESS(ra), .TARGET_ACCESS(ta), .REFRESH_ACCESS(fa), .RELOAD_BUSY(rb),
        .ACTIVE_CHANNEL(ach), .CHANNEL_DONE(done), .LOWER_ROTATING(lr), .UPPER_ROTATING(ur),
        .LOWER_LOWEST(ll), .UPPER_LOWEST(ul));
    dtmp_host_model host (.clock(clk), .reset(rst), .hold_request(hold), .ack_delay(dly),
        .hold_ack(ack));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Walks the upper slots from lowest to highest; the last requester met wins.
    function [2:0] pick(input [7:0] q);
        integer i, j;
        reg [2:0] s;
        reg [1:0] c;
        begin
            pick = 3'h0;
            for (i = 5; i > 0; i = i - 1) begin
                s = (mul + i) % 5;
                if (s == 3'h4) begin
                    for (j = 4; j > 0; j = j - 1) begin
                        c = (mll + j) % 4;
                        if (q[c]) pick = {1'b0, c};
                    end
                end else if (q[s + 4]) pick = s + 3'h4;
            end
        end
    endfunction
    task cmp(input [15:0] got, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Loading a count also clears a channel's done flag, so all eight are written.
    task load(input [15:0] v);
        begin
            for (k = 0; k < 8; k = k + 1) begin
                @(negedge clk);
                cw = 1'b1;
                cch = k[2:0];
                cval = v;
            end
            @(negedge clk);
            cw = 1'b0;
        end
    endtask
    task prio(input mw, input grp, input rot, input [1:0] low);
        begin
            @(negedge clk);
            pmw = mw;
            ppw = !mw;
            pg = grp;
            pr = rot;
            pl = low;
            @(negedge clk);
            pmw = 1'b0;
            ppw = 1'b0;
        end
    endtask
    // One service: requests drop at the first requester access, as a peripheral may.
    task run(input [7:0] q, input e, input [15:0] acc, input [3:0] gap, input dn);
        begin
            w = pick(q);
            seed = xs(seed);
            dly = seed[1:0];
            @(negedge clk);
            req = q;
            for (n = 0; n < 60 && !ra; n = n + 1) @(negedge clk);
            cmp({13'h0, ach}, {13'h0, w});
            if (mlr && !w[2]) mll = w[1:0];
            if (mur) mul = w[2] ? {1'b0, w[1:0]} : 3'h4;
            cmp({14'h0, ll}, {14'h0, mll});
            cmp({13'h0, ul}, {13'h0, mul});
            req = 8'h00;
            eop = e;
            n = 1;
            g = 0;
            f = 0;
            for (k = 0; k < 200 && hold; k = k + 1) begin
                @(negedge clk);
                eop = 1'b0;
                n = n + ra;
                f = f + fa;
                g = ta ? 0 : g + 1;
            end
            cmp(n[15:0], acc);
            cmp(f[15:0], rfsh ? acc - 16'h1 : 16'h0);
            if (gap != 4'h0) cmp(g[15:0], {12'h0, gap});
            cmp({15'h0, done[w]}, {15'h0, dn});
            repeat (3) @(negedge clk);
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        cmp({lr, ur, ll, ul, hold, done}, {2'b00, 2'h3, 3'h3, 1'b0, 8'h00});
        for (r = 0; r < 12; r = r + 1) begin
            seed = xs(seed);
            m = seed[7:0] | {seed[7:0] == 8'h00, 7'h00};
            rfsh = seed[10];
            load({14'h0, seed[9:8]});
            run(m, seed[12], seed[12] ? 16'h1 : {14'h0, seed[9:8]} + 16'h1, 4'h1, 1'b1);
        end
        rfsh = 1'b0;
        prio(1'b0, 1'b0, 1'b0, 2'h1);
        mll = 2'h1;
        load(16'h0);
        run(8'h05, 1'b0, 16'h1, 4'h1, 1'b1);
        prio(1'b0, 1'b1, 1'b0, 2'h1);
        mul = 3'h1;
        load(16'h0);
        run(8'h55, 1'b0, 16'h1, 4'h1, 1'b1);
        prio(1'b0, 1'b1, 1'b0, 2'h3);
        mul = 3'h3;
        prio(1'b1, 1'b0, 1'b1, 2'h0);
        prio(1'b1, 1'b1, 1'b1, 2'h0);
        mlr = 1'b1;
        mur = 1'b1;
        cmp({14'h0, lr, ur}, 16'h0003);
        prio(1'b0, 1'b0, 1'b0, 2'h3);
        cmp({14'h0, ll}, 16'h0001);
        for (r = 0; r < 5; r = r + 1) begin
            load(16'h0);
            run(tbl[39 - 8 * r -: 8], 1'b0, 16'h1, 4'h1, 1'b1);
        end
        prio(1'b1, 1'b0, 1'b0, 2'h0);
        prio(1'b1, 1'b1, 1'b0, 2'h0);
        {mlr, mur, mll, mul} = {2'b00, 2'h1, 3'h3};
        cmp({9'h0, lr, ur, ll, ul}, {9'h0, 2'b00, 2'h1, 3'h3});
        dem = 8'h02;
        load(16'h3);
        for (r = 0; r < 4; r = r + 1) run(8'h02, 1'b0, 16'h1, 4'h1, r == 3);
        dem = 8'h00;
        ai = 8'h08;
        load(16'h1);
        run(8'h08, 1'b0, 16'h2, 4'h8, 1'b0);
        {ai, src, tc} = {8'h00, 8'h20, 8'h20};
        load(16'h0);
        run(8'h20, 1'b0, 16'h1, 4'h3, 1'b1);
        close_out;
    end
    // Cuts a hang short at 8000 cycles, well past the few hundred cycles the run needs.
    initial begin
        #(50 * 8000);
        bad_count = bad_count + 1;
        close_out;
    end
endmodule
bind dtmp_core dtmp_checker chk_i (.CLOCK, .RESET, .CHANNEL_SERVICE_REQUEST, .BUS_HOLD_ACK,
    .REFRESH_REQUEST, .CHANNEL_DEMAND_MODE, .CHANNEL_AUTO_INIT, .CHANNEL_REQUESTER_SOURCE,
    .CHANNEL_TWO_CYCLE, .PRIORITY_MODE_WRITE, .PRIORITY_GROUP, .PROGRAM_PRIORITY_WRITE,
    .PROGRAM_LOWEST, .BUS_HOLD_REQUEST, .REQUESTER_ACCESS, .TARGET_ACCESS, .RELOAD_BUSY,
    .ACTIVE_CHANNEL, .LOWER_ROTATING, .UPPER_ROTATING, .LOWER_LOWEST, .UPPER_LOWEST);
